/* File: pswio_motion_model.sv */
`timescale 1ns/10ps
module pswio_motion_model
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Commands from the block
	input wire pswio_pkg::pswio_mot_cmd_t cmd_i,
	// Scenario controls
	input wire logic miss_i,
	input wire logic batt_i,
	input wire logic [7:0] dly_i,
	// Feedback to the block
	output pswio_pkg::pswio_mot_sts_t mot_o
);
	import pswio_pkg::*;
	logic [7:0] cnt_r;
	logic busy_r;
	logic push_r;
	logic home_r;

	// Travel takes dly_i + 1 cycles, frozen while held, dropped on abort
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			mot_o <= '0;
			busy_r <= 1'b0;
			cnt_r <= 8'h00;
			push_r <= 1'b0;
			home_r <= 1'b0;
		end
		else
		begin
			mot_o <= '0;
			mot_o.init_done <= 1'b1;
			mot_o.batt_low <= batt_i;
			if (cmd_i.move_req | cmd_i.home_req)
			begin
				busy_r <= 1'b1;
				cnt_r <= dly_i;
				home_r <= cmd_i.home_req;
				push_r <= cmd_i.push_mode;
			end
			else if (cmd_i.abort)
				busy_r <= 1'b0;
			else if (busy_r & !cmd_i.hold)
			begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h00)
				begin
					busy_r <= 1'b0;
					mot_o.home_done <= home_r;
					mot_o.move_done <= !home_r;
					mot_o.push_ok <= push_r & !miss_i;
					mot_o.push_miss <= push_r & miss_i;
				end
			end
		end
	end
endmodule

/* File: pswio_pkg.sv */
package pswio_pkg;

	// Clock and input filter timing
	localparam int CLK_KHZ = 40000;
	localparam int DEB_TIME_US = 6000;
	localparam int DEB_CYC = (DEB_TIME_US * CLK_KHZ) / 1000;
	localparam int DEB_W = 18;

	// Code word and position table limits
	localparam int CODE_W = 16;
	localparam int PIN_W = 24;
	localparam logic [31:0] MAX_POINTS = 32'h0000_05dc;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_POS_BITS = 8'h04;
	localparam logic [7:0] REG_PER_PROD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_TARGET = 8'h10;
	localparam logic [7:0] REG_ERROR = 8'h14;

	// Field positions
	localparam int CTRL_BCD_BIT = 0;
	localparam int CTRL_TWO_AXIS_BIT = 1;
	localparam int ERR_HOME_BIT = 0;
	localparam int ERR_POINT_BIT = 1;
	localparam int ERR_EXT_BIT = 2;

	// Values after reset
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [3:0] POS_BITS_RST = 4'h6;
	localparam logic [15:0] PER_PROD_RST = 16'h0032;
	localparam logic [23:0] PIN_RST = 24'h06_0000;

	// AHB-Lite encodings
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_MOVE = 2'b01,
		ST_HOME = 2'b10
	} pswio_state_t;

	// Host-driven parallel inputs, already at logic level
	typedef struct packed
	{
		logic alarm_clear_in;
		logic move_go_in;
		logic home_go_in;
		logic servo_enable_in;
		logic push_req_in;
		logic hold_n_in;
		logic abort_n_in;
		logic interp_req_in;
		logic [15:0] code_in;
	} pswio_pins_t;

	// Status outputs towards the host
	typedef struct packed
	{
		logic fault_n_out;
		logic ready_out;
		logic in_position_out;
		logic homed_out;
		logic servo_active_out;
		logic push_done_out;
		logic backup_battery_low_out;
	} pswio_stat_t;

	// Feedback from the motion engine
	typedef struct packed
	{
		logic init_done;
		logic move_done;
		logic home_done;
		logic push_ok;
		logic push_miss;
		logic fault_evt;
		logic batt_low;
	} pswio_mot_sts_t;

	// Commands to the motion engine
	typedef struct packed
	{
		logic move_req;
		logic home_req;
		logic servo_drive;
		logic hold;
		logic abort;
		logic push_mode;
		logic interp_mode;
		logic [15:0] target;
	} pswio_mot_cmd_t;

endpackage

/* File: pswio_top.sv */
`timescale 1ns/10ps
module pswio_top
#(
	parameter int DEB_CYCLES = pswio_pkg::DEB_CYC
)
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Parallel host pins
	input wire pswio_pkg::pswio_pins_t pins_i,
	output pswio_pkg::pswio_stat_t stat_o,
	// Motion engine
	input wire pswio_pkg::pswio_mot_sts_t mot_i,
	output pswio_pkg::pswio_mot_cmd_t cmd_o
);
	import pswio_pkg::*;

	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYCLES - 1);

	// Refuse filter lengths the counter cannot hold
	if (DEB_CYCLES < 1 || DEB_CYCLES > (2 ** DEB_W))
	begin : g_bad_deb
		$error("DEB_CYCLES out of range for the filter counter");
	end

	logic [PIN_W-1:0] sync1_r;
	logic [PIN_W-1:0] sync2_r;
	logic [PIN_W-1:0] filt;
	pswio_pins_t pf;
	pswio_pins_t prev_r;
	pswio_state_t state_r;
	pswio_state_t state_nxt;
	logic [1:0] ctrl_r;
	logic [3:0] pos_bits_r;
	logic [15:0] per_prod_r;
	logic [2:0] err_r;
	logic [2:0] err_nxt;
	logic homed_r;
	logic arrived_r;
	logic in_pos_r;
	logic push_r;
	logic servo_drive_r;
	logic ready_r;
	logic wr_in_position_out_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	pswio_stat_t stat_r;
	pswio_mot_cmd_t cmd_r;

	// Two-stage synchroniser for every host input
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync1_r <= PIN_RST;
			sync2_r <= PIN_RST;
		end
		else
		begin
			sync1_r <= pins_i;
			sync2_r <= sync1_r;
		end
	end

	// Per-input filter: a new level counts only after it has stood DEB_CYCLES
	for (genvar b = 0; b < PIN_W; b++)
	begin : g_filt
		logic [DEB_W-1:0] cnt_r;
		logic flt_r;
		always_ff @(posedge ref_clk_i)
		begin
			if (!rst_n_i)
			begin
				cnt_r <= '0;
				flt_r <= PIN_RST[b];
			end
			else if (sync2_r[b] == flt_r)
				cnt_r <= '0;
			else if (cnt_r == DEB_LAST)
			begin
				cnt_r <= '0;
				flt_r <= sync2_r[b];
			end
			else
				cnt_r <= cnt_r + 1'b1;
		end
		assign filt[b] = flt_r;
	end

	assign pf = filt;

	// Previous filtered levels for edge detection
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			prev_r <= PIN_RST;
		else
			prev_r <= pf;
	end

	wire start_rise = pf.move_go_in & ~prev_r.move_go_in;
	wire home_rise = pf.home_go_in & ~prev_r.home_go_in;
	wire clr_rise = pf.alarm_clear_in & ~prev_r.alarm_clear_in;
	wire abort_fell = ~pf.abort_n_in & prev_r.abort_n_in;

	// BCD word to binary, four digits
	function automatic logic [15:0] bcd2bin(input logic [15:0] v);
		return 16'(v[3:0] + (v[7:4] * 10) + (v[11:8] * 100) + (v[15:12] * 1000));
	endfunction

	// Split the code word into position and product fields
	wire bcd_mode = ctrl_r[CTRL_BCD_BIT];
	wire [4:0] fld_w = bcd_mode ? {1'b0, pos_bits_r[1:0], 2'b00} : {1'b0, pos_bits_r};
	wire [16:0] mask_w = (17'h0_0001 << fld_w) - 17'h0_0001;
	wire [15:0] pos_raw = pf.code_in & mask_w[15:0];
	wire [15:0] prod_raw = pf.code_in >> fld_w;
	wire [15:0] pos_val = bcd_mode ? bcd2bin(pos_raw) : pos_raw;
	wire [15:0] prod_val = bcd_mode ? bcd2bin(prod_raw) : prod_raw;

	// Out-of-range position numbers fall back to position 1
	wire pos_bad = (pos_val > per_prod_r) || (pos_val == 16'h0000);
	wire [15:0] pos_eff = pos_bad ? 16'h0001 : pos_val;

	// Target index depends on product as well as position
	wire [31:0] idx_base = ({16'h0000, prod_val} - 32'h0000_0001) * {16'h0000, per_prod_r};
	wire [31:0] idx_wide = idx_base + {16'h0000, pos_eff};
	wire pt_err = (prod_val == 16'h0000) || (idx_wide > MAX_POINTS);

	// Command acceptance
	wire alarm_any = |err_r;
	wire idle = (state_r == ST_IDLE);
	wire can_cmd = idle & servo_drive_r & ready_r & ~alarm_any;
	wire go_ok = start_rise & can_cmd & pf.hold_n_in & pf.abort_n_in;
	wire go_home_err = go_ok & ~homed_r;
	wire go_pt_err = go_ok & homed_r & pt_err;
	wire go_move = go_ok & homed_r & ~pt_err;
	wire home_go = home_rise & can_cmd & ~start_rise;
	wire stop_ev = abort_fell & ~idle;
	wire push_fin = cmd_r.push_mode & (mot_i.push_ok | mot_i.push_miss);
	wire move_end = (state_r == ST_MOVE) & (mot_i.move_done | push_fin);
	wire home_end = (state_r == ST_HOME) & mot_i.home_done;

	// Motion sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (go_move)
					state_nxt = ST_MOVE;
				else if (home_go)
					state_nxt = ST_HOME;
			end
			ST_MOVE:
			begin
				if (stop_ev || move_end)
					state_nxt = ST_IDLE;
			end
			ST_HOME:
			begin
				if (stop_ev || home_end)
					state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Alarms: a new event wins over a clear in the same cycle
	wire [2:0] err_set = {mot_i.fault_evt, go_pt_err, go_home_err};
	assign err_nxt = (err_r & ~{3{clr_rise}}) | err_set;

	// Servo follows its enable, but cannot drop while a motion runs
	wire servo_nxt = idle ? pf.servo_enable_in : servo_drive_r;

	// Arrival, homing and push results
	wire arrived_nxt = (go_move | home_go) ? 1'b0 : ((move_end | home_end) ? 1'b1 : arrived_r);
	wire homed_nxt = home_go ? 1'b0 : (home_end ? 1'b1 : homed_r);
	wire push_ok_ev = (state_r == ST_MOVE) & cmd_r.push_mode & mot_i.push_ok;
	wire push_miss_ev = (state_r == ST_MOVE) & cmd_r.push_mode & mot_i.push_miss;
	wire push_nxt = (go_move | push_miss_ev) ? 1'b0 : (push_ok_ev ? 1'b1 : push_r);
	wire pos_keep = pf.hold_n_in & servo_drive_r & ~go_move & ~home_go;
	wire pos_set = arrived_r & ~pf.move_go_in & ready_r;
	wire in_pos_nxt = (in_pos_r | pos_set) & pos_keep;

	// Sequencer and status state
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ST_IDLE;
			err_r <= 3'h0;
			homed_r <= 1'b0;
			arrived_r <= 1'b1;
			in_pos_r <= 1'b0;
			push_r <= 1'b0;
			servo_drive_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			err_r <= err_nxt;
			homed_r <= homed_nxt;
			arrived_r <= arrived_nxt;
			in_pos_r <= in_pos_nxt;
			push_r <= push_nxt;
			servo_drive_r <= servo_nxt;
			ready_r <= mot_i.init_done;
		end
	end

	// Commands to the motion engine, registered
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			cmd_r <= '0;
		else
		begin
			cmd_r.move_req <= go_move;
			cmd_r.home_req <= home_go;
			cmd_r.servo_drive <= servo_nxt;
			cmd_r.hold <= ~pf.hold_n_in;
			cmd_r.abort <= stop_ev;
			if (go_move)
			begin
				cmd_r.push_mode <= pf.push_req_in;
				cmd_r.interp_mode <= pf.interp_req_in & ctrl_r[CTRL_TWO_AXIS_BIT];
				cmd_r.target <= idx_wide[15:0];
			end
		end
	end

	// Host status outputs, registered; handshake holds completions while start is high
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			stat_r <= '0;
		else
		begin
			stat_r.fault_n_out <= ~alarm_any;
			stat_r.ready_out <= ready_r;
			stat_r.in_position_out <= in_pos_r;
			stat_r.homed_out <= homed_r;
			stat_r.servo_active_out <= servo_drive_r;
			stat_r.push_done_out <= push_r & ~pf.move_go_in;
			stat_r.backup_battery_low_out <= mot_i.batt_low;
		end
	end

	assign stat_o = stat_r;
	assign cmd_o = cmd_r;

	// AHB-Lite address phase decode; zero wait states, always OKAY
	wire ahb_take = hsel_i & hready_i & htrans_i[1];
	wire [7:0] a_off = haddr_i[7:0];
	wire [31:0] rd_val =
		(a_off == REG_CTRL) ? {30'h0, ctrl_r} :
		(a_off == REG_POS_BITS) ? {28'h0, pos_bits_r} :
		(a_off == REG_PER_PROD) ? {16'h0, per_prod_r} :
		(a_off == REG_STATUS) ? {23'h0, state_r, stat_r} :
		(a_off == REG_TARGET) ? {16'h0, cmd_r.target} :
		(a_off == REG_ERROR) ? {29'h0, err_r} : 32'h0;

	// Capture write address and read data at the address phase
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_in_position_out_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0;
		end
		else
		begin
			wr_in_position_out_r <= ahb_take & hwrite_i;
			if (ahb_take)
				wr_addr_r <= a_off;
			if (ahb_take & ~hwrite_i)
				hrdata_r <= rd_val;
		end
	end

	// Data phase writes to configuration registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_r <= CTRL_RST;
			pos_bits_r <= POS_BITS_RST;
			per_prod_r <= PER_PROD_RST;
		end
		else if (wr_in_position_out_r)
		begin
			if (wr_addr_r == REG_CTRL)
				ctrl_r <= hwdata_i[1:0];
			else if (wr_addr_r == REG_POS_BITS)
				pos_bits_r <= hwdata_i[3:0];
			else if (wr_addr_r == REG_PER_PROD)
				per_prod_r <= hwdata_i[15:0];
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = HRESP_OKAY;
	assign hrdata_o = hrdata_r;

	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_alarm_clear;
		clr_rise && (err_set == 3'h0) |=> (err_r == 3'h0) ##1 stat_o.fault_n_out;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm clear missed");

	sequence s_move_issued;
		cmd_o.move_req && (state_r == ST_MOVE);
	endsequence
	property p_start_move;
		go_move |=> s_move_issued ##1 !cmd_o.move_req;
	endproperty
	a_start_move: assert property (p_start_move) else $error("start not issued");

	property p_home_go;
		home_go |=> cmd_o.home_req && (state_r == ST_HOME) && !homed_r;
	endproperty
	a_home_go: assert property (p_home_go) else $error("home return not issued");

	property p_servo_follow;
		idle && (pf.servo_enable_in != servo_drive_r) |=> ##1 (stat_o.servo_active_out == $past(pf.servo_enable_in, 2));
	endproperty
	a_servo_follow: assert property (p_servo_follow) else $error("servo state lags");

	property p_push_mode;
		go_move |=> (cmd_o.push_mode == $past(pf.push_req_in));
	endproperty
	a_push_mode: assert property (p_push_mode) else $error("push mode not taken");

	property p_hold;
		!pf.hold_n_in [*3] |-> cmd_o.hold && !stat_r.in_position_out;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not obeyed");

	property p_abort;
		stop_ev |=> cmd_o.abort && (state_r == ST_IDLE);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not issued");

	property p_fault_out;
		(err_r != 3'h0) |=> !stat_o.fault_n_out;
	endproperty
	a_fault_out: assert property (p_fault_out) else $error("fault output high with alarm");

	property p_home_incomplete;
		go_ok && !homed_r |=> err_r[ERR_HOME_BIT] && (state_r == ST_IDLE) && !cmd_o.move_req;
	endproperty
	a_home_incomplete: assert property (p_home_incomplete) else $error("missing home error");

	property p_in_position_out_after_start;
		$rose(stat_o.in_position_out) |-> !$past(pf.move_go_in, 2) && $past(arrived_r, 2);
	endproperty
	a_in_position_out_after_start: assert property (p_in_position_out_after_start) else $error("early in-position");

	property p_homed_end;
		home_end |=> homed_r ##1 stat_o.homed_out;
	endproperty
	a_homed_end: assert property (p_homed_end) else $error("homed not set");

endmodule

/* File: pswio_top_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module pswio_top_tb;
	import pswio_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic miss = 1'b0;
	logic batt = 1'b0;
	logic [7:0] dly = 8'h05;
	pswio_pins_t pins = PIN_RST; // Hold and abort contacts closed
	wire logic hrdy;
	wire logic [31:0] hrdata;
	pswio_stat_t stat;
	pswio_mot_sts_t mot;
	pswio_mot_cmd_t cmd;
	logic [31:0] rd;
	int err_count = 0;
	int checks = 0;
	logic [7:0] ra [4] = '{REG_CTRL, REG_POS_BITS, REG_PER_PROD, 8'h18};
	logic [31:0] rv [4] = '{32'h0, 32'h6, 32'h32, 32'h0};

	// Free-running bus clock
	always #12.5 ref_clk_i = ~ref_clk_i;

	pswio_top #(.DEB_CYCLES(4)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
		.hresp_o(), .hrdata_o(hrdata), .pins_i(pins), .stat_o(stat),
		.mot_i(mot), .cmd_o(cmd));

	pswio_motion_model mdl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
		.miss_i(miss), .batt_i(batt), .dly_i(dly), .mot_o(mot));

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Waits for hready under a bound
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge ref_clk_i);
		while (hrdy !== 1'b1 && n < 16)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		if (hrdy !== 1'b1)
		begin
			err_count++;
			wrap_up();
		end
	endtask

	task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk_i);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		ahb_xfer(a, 1'b0, 32'h0);
		`CHK("register", e, rd)
	endtask

	// Code word, start, target check, start released, arrival check
	task automatic do_move(input logic [15:0] c, input logic [31:0] e);
		@(posedge ref_clk_i) pins.code_in <= c;
		settle(12); // Code settled before start
		@(posedge ref_clk_i) pins.move_go_in <= 1'b1;
		settle(24);
		chk_reg(REG_TARGET, e);
		@(posedge ref_clk_i) pins.move_go_in <= 1'b0;
		settle(12);
		`CHK("in_position", 1'b1, stat.in_position_out)
	endtask

	// Main sequence
	initial
	begin
		settle(8);
		`CHK("stat_reset", 7'h00, stat)
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++)
			chk_reg(ra[i], rv[i]);
		settle(12);
		`CHK("ready", 1'b1, stat.ready_out)
		`CHK("fault_n", 1'b1, stat.fault_n_out)
		pins.servo_enable_in <= 1'b1;
		settle(12);
		`CHK("servo", 1'b1, stat.servo_active_out)
		pins.code_in <= {10'd2, 6'd49};
		settle(12);
		pins.move_go_in <= 1'b1;
		settle(12);
		chk_reg(REG_ERROR, 32'h1);
		`CHK("fault_n", 1'b0, stat.fault_n_out)
		pins.move_go_in <= 1'b0;
		pins.alarm_clear_in <= 1'b1;
		settle(12);
		chk_reg(REG_ERROR, 32'h0);
		`CHK("fault_n", 1'b1, stat.fault_n_out)
		pins.alarm_clear_in <= 1'b0;
		pins.home_go_in <= 1'b1;
		settle(20);
		`CHK("homed", 1'b1, stat.homed_out)
		pins.home_go_in <= 1'b0;
		settle(12);
		do_move({10'd2, 6'd49}, 32'd99);
		do_move({10'd1, 6'd49}, 32'd49);
		do_move({10'd3, 6'd60}, 32'd101);
		pins.hold_n_in <= 1'b0;
		settle(12);
		`CHK("in_position", 1'b0, stat.in_position_out)
		pins.hold_n_in <= 1'b1;
		pins.push_req_in <= 1'b1;
		do_move({10'd1, 6'd2}, 32'd2);
		`CHK("push_mode", 1'b1, cmd.push_mode)
		`CHK("push_done", 1'b1, stat.push_done_out)
		miss <= 1'b1;
		do_move({10'd1, 6'd3}, 32'd3);
		`CHK("push_done", 1'b0, stat.push_done_out)
		pins.push_req_in <= 1'b0;
		miss <= 1'b0;
		ahb_xfer(REG_CTRL, 1'b1, 32'h3);
		ahb_xfer(REG_POS_BITS, 1'b1, 32'h2);
		pins.interp_req_in <= 1'b1;
		do_move(16'h0249, 32'd99);
		`CHK("interp", 1'b1, cmd.interp_mode)
		pins.interp_req_in <= 1'b0;
		dly <= 8'hc8;
		pins.code_in <= 16'h0211;
		settle(12);
		pins.move_go_in <= 1'b1;
		settle(24);
		// Moving: state ST_MOVE in bits 8:7, fault_n, ready, homed and servo high, the rest low
		chk_reg(REG_STATUS, 32'h0000_00ec);
		pins.abort_n_in <= 1'b0;
		settle(12);
		ahb_xfer(REG_STATUS, 1'b0, 32'h0);
		`CHK("state", 2'h0, rd[8:7])
		pins.abort_n_in <= 1'b1;
		pins.move_go_in <= 1'b0;
		batt <= 1'b1;
		settle(12);
		`CHK("battery", 1'b1, stat.backup_battery_low_out)
		// Product number zero must raise a point error, not a move
		pins.code_in <= 16'h0005;
		settle(12);
		pins.move_go_in <= 1'b1;
		settle(12);
		chk_reg(REG_ERROR, 32'h2);
		wrap_up();
	end
endmodule
